/* File: core/csa_regs.vh */
// register addresses, field positions, selector codes and limits for the status and alarm bank
`ifndef CSA_REGS_VH
`define CSA_REGS_VH

`define CSA_ADDR_W            16
`define CSA_DATA_W            16
`define CSA_ADDR_DISPLAY_ONE  16'h0038
`define CSA_ADDR_DISPLAY_TWO  16'h0039
`define CSA_ADDR_DISPLAY_THR  16'h003A
`define CSA_ADDR_DISPLAY_FOUR 16'h003B
`define CSA_ADDR_STATUS       16'h003C
`define CSA_ADDR_ALARM_ONE    16'h003D
`define CSA_ADDR_ALARM_TWO    16'h003E
`define CSA_ADDR_ALARM_THREE  16'h003F

`define CSA_ST_RUN            0
`define CSA_ST_STOP_ALARM     1
`define CSA_ST_CONT_ALARM     2
`define CSA_ST_MAINT_NOTICE   3
`define CSA_ST_READY_ONE      4
`define CSA_ST_READY_TWO      5
`define CSA_ST_TEMP_OUT       6
`define CSA_ST_EXT_TUNE       12
`define CSA_ST_WARM_UP        13
`define CSA_ST_STARTUP        14
`define CSA_ST_ANTI_FREEZE    15

`define CSA_AL1_LVL_ONE_ABN   0
`define CSA_AL1_LVL_ONE_LOW   1
`define CSA_AL1_LVL_TWO_ABN   2
`define CSA_AL1_LVL_TWO_LOW   3
`define CSA_AL1_FAN_FAIL      5
`define CSA_AL1_ONE_RISE_ABN  8
`define CSA_AL1_ONE_RISE      9
`define CSA_AL1_ONE_DROP      10
`define CSA_AL1_ONE_READY     11
`define CSA_AL1_TWO_RISE_ABN  12
`define CSA_AL1_TWO_RISE      13
`define CSA_AL1_TWO_DROP      14
`define CSA_AL1_TWO_READY     15

`define CSA_AL2_ONE_INLET_HOT 0
`define CSA_AL2_ONE_PSENS     1
`define CSA_AL2_ONE_PRES_RISE 2
`define CSA_AL2_ONE_PRES_DROP 3
`define CSA_AL2_TWO_INLET_HOT 4
`define CSA_AL2_TWO_PSENS     5
`define CSA_AL2_TWO_PRES_RISE 6
`define CSA_AL2_TWO_PRES_DROP 7
`define CSA_AL2_TWO_PRES_ABN  8
`define CSA_AL2_TWO_FLOW_FAIL 9
`define CSA_AL2_TWO_COND_UP   10
`define CSA_AL2_CONTACT_ONE   13
`define CSA_AL2_CONTACT_TWO   14

`define CSA_AL3_COMM_ERR      1
`define CSA_AL3_AMBIENT_OUT   2
`define CSA_AL3_MAINT_ALARM   3
`define CSA_AL3_COMP_CIRCUIT  4
`define CSA_AL3_SENSOR_FAIL   5
`define CSA_AL3_CTRL_FAIL     6
`define CSA_AL3_COMP_INV_ERR  7
`define CSA_AL3_COMP_INV_COMM 8
`define CSA_AL3_PUMP_ONE_ERR  9
`define CSA_AL3_PUMP_ONE_COMM 10
`define CSA_AL3_PUMP_TWO_ERR  11
`define CSA_AL3_PUMP_TWO_COMM 12

`define CSA_AL1_USED_MASK     16'hFF2F
`define CSA_AL2_USED_MASK     16'h67FF
`define CSA_AL3_USED_MASK     16'h1FFE

`define CSA_SEL_NONE          4'h0
`define CSA_SEL_AMBIENT       4'h1
`define CSA_SEL_EXT_TUNE      4'h2
`define CSA_SEL_HX_INLET      4'h3
`define CSA_SEL_MAINT         4'h4
`define CSA_SEL_PRESSURE      4'h5

`define CSA_LIMIT_LOW         16'hF334
`define CSA_LIMIT_HIGH        16'h0CCC
`define CSA_EXT_TUNE_OFF      16'hF334
`define CSA_RESET_WORD        16'h0000

`endif

/* File: core/csa_display_sel.v */
// one display word: selector decode with clamping of signed quantities
`timescale 1ns/1ps
`include "csa_regs.vh"

module csa_display_sel (
  // selection
  input  wire [3:0]  sel_i,
  input  wire        ext_tune_on_i,
  // quantities
  input  wire [15:0] ambient_temp_i,
  input  wire [15:0] ext_tune_temp_i,
  input  wire [15:0] hx_inlet_temp_i,
  input  wire [15:0] maint_notice_i,
  input  wire [15:0] hp_pressure_i,
  // result
  output reg  [15:0] word_o
);

  function [15:0] clamp;
    input [15:0] v;
    begin
      if ($signed(v) < $signed(`CSA_LIMIT_LOW))
        clamp = `CSA_LIMIT_LOW;
      else if ($signed(v) > $signed(`CSA_LIMIT_HIGH))
        clamp = `CSA_LIMIT_HIGH;
      else
        clamp = v;
    end
  endfunction

  always @* begin
    case (sel_i) // [RL14]
      `CSA_SEL_AMBIENT:  word_o = clamp(ambient_temp_i); // [RL15]
      `CSA_SEL_EXT_TUNE: word_o = ext_tune_on_i ? clamp(ext_tune_temp_i) : `CSA_EXT_TUNE_OFF; // [RL18]
      `CSA_SEL_HX_INLET: word_o = clamp(hx_inlet_temp_i); // [RL15]
      `CSA_SEL_MAINT:    word_o = maint_notice_i; // [RL17]
      `CSA_SEL_PRESSURE: word_o = clamp(hp_pressure_i); // [RL16]
      // codes 0 and 6..15 read as zero
      default:           word_o = `CSA_RESET_WORD;
    endcase
  end

endmodule // csa_display_sel

/* File: core/csa_status_alarm_regs.v */
// read-only status, alarm and display word bank with word-addressed read port
// Notes on behaviour
// RL1 - bits 0-2: run, stop alarm, continue alarm
// RL2 - bit 3 shows maintenance notice generated
// RL3 - bits 4,5 show per-channel readiness condition
// RL4 - bit 6 shows out-of-band temperature condition
// RL5 - bits 12-15: tuning, warm-up, startup, anti-freeze
// RL6 - alarm bits read 1 while alarm occurs
// RL7 - alarm one low bits: levels, fan
// RL8 - alarm one high bits: channel temperature alarms
// RL9 - alarm two bits 0-3: channel one
// RL10 - alarm two bits 4-10: channel two faults
// RL11 - alarm two bits 13,14: contact inputs
// RL12 - alarm three bits 1-5 system faults
// RL13 - alarm three bits 6-12 controller, inverters
// RL14 - display word follows its selector code
// RL15 - temperatures signed, clamped F334h..0CCCh
// RL16 - pressure signed, clamped F334h..0CCCh
// RL17 - maintenance item is a bit set
// RL18 - tuning off forces F334h on display
// RL19 - selector holds four nibbles, low first
// RL20 - words at 0038h..003Fh, read-only
// RL21 - reserved bits read zero
// RL22 - bits follow live condition, no latching
`timescale 1ns/1ps
`include "csa_regs.vh"

module csa_status_alarm_regs (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // read port from the serial front end
  input  wire        rd_en_i,
  input  wire [15:0] rd_addr_i,
  output reg  [15:0] rd_data_o,
  output reg         rd_valid_o,
  output reg         rd_addr_err_o,
  // display selector word from the write side
  input  wire [15:0] data_select_i,
  // machine state, raw from plant logic in other domains
  input  wire        running_i,
  input  wire        stop_alarm_i,
  input  wire        cont_alarm_i,
  input  wire        maint_notice_flag_i,
  input  wire        ready_channel_one_i,
  input  wire        ready_channel_two_i,
  input  wire        temp_out_i,
  input  wire        ext_tune_on_i,
  input  wire        warm_up_on_i,
  input  wire        startup_on_i,
  input  wire        anti_freeze_on_i,
  // raw alarm vectors, one bit per condition in word layout
  input  wire [15:0] alarm_one_i,
  input  wire [15:0] alarm_two_i,
  input  wire [15:0] alarm_three_i,
  // monitored quantities, already on this clock
  input  wire [15:0] ambient_temp_i,
  input  wire [15:0] ext_tune_temp_i,
  input  wire [15:0] hx_inlet_temp_i,
  input  wire [15:0] maint_notice_i,
  input  wire [15:0] hp_pressure_i
);

  // two-stage synchronisers for asynchronous level inputs
  reg  [10:0] flag_meta;
  reg  [10:0] flag_sync;
  reg  [15:0] al1_meta;
  reg  [15:0] al1_sync;
  reg  [15:0] al2_meta;
  reg  [15:0] al2_sync;
  reg  [15:0] al3_meta;
  reg  [15:0] al3_sync;

  // machine flags gathered in status bit order, spare positions closed up
  wire [10:0] flag_raw;
  assign flag_raw[0]  = running_i;
  assign flag_raw[1]  = stop_alarm_i;
  assign flag_raw[2]  = cont_alarm_i;
  assign flag_raw[3]  = maint_notice_flag_i;
  assign flag_raw[4]  = ready_channel_one_i;
  assign flag_raw[5]  = ready_channel_two_i;
  assign flag_raw[6]  = temp_out_i;
  assign flag_raw[7]  = ext_tune_on_i;
  assign flag_raw[8]  = warm_up_on_i;
  assign flag_raw[9]  = startup_on_i;
  assign flag_raw[10] = anti_freeze_on_i;

  // every bit is an independent level, so a per-bit two-stage sync is enough;
  // a multi-bit number would need a handshake or gray code instead
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flag_meta <= 11'h000;
      flag_sync <= 11'h000;
    end else begin
      flag_meta <= flag_raw;
      flag_sync <= flag_meta;
    end
  end

  // alarm word one raw bits
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      al1_meta <= `CSA_RESET_WORD;
      al1_sync <= `CSA_RESET_WORD;
    end else begin
      al1_meta <= alarm_one_i;
      al1_sync <= al1_meta;
    end
  end

  // alarm word two raw bits
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      al2_meta <= `CSA_RESET_WORD;
      al2_sync <= `CSA_RESET_WORD;
    end else begin
      al2_meta <= alarm_two_i;
      al2_sync <= al2_meta;
    end
  end

  // alarm word three raw bits
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      al3_meta <= `CSA_RESET_WORD;
      al3_sync <= `CSA_RESET_WORD;
    end else begin
      al3_meta <= alarm_three_i;
      al3_sync <= al3_meta;
    end
  end

  // synchronised flags by name
  wire        run_flag;
  wire        stop_alarm_flag;
  wire        cont_alarm_flag;
  wire        maint_flag;
  wire        ready_one_flag;
  wire        ready_two_flag;
  wire        temp_out_flag;
  wire        ext_tune_flag;
  wire        warm_up_flag;
  wire        startup_flag;
  wire        anti_freeze_flag;
  assign run_flag         = flag_sync[0];
  assign stop_alarm_flag  = flag_sync[1];
  assign cont_alarm_flag  = flag_sync[2];
  assign maint_flag       = flag_sync[3];
  assign ready_one_flag   = flag_sync[4];
  assign ready_two_flag   = flag_sync[5];
  assign temp_out_flag    = flag_sync[6];
  assign ext_tune_flag    = flag_sync[7];
  assign warm_up_flag     = flag_sync[8];
  assign startup_flag     = flag_sync[9];
  assign anti_freeze_flag = flag_sync[10];

  // status word assembled live every cycle, nothing is latched [RL22]
  reg  [15:0] machine_status_word;
  always @* begin
    machine_status_word = `CSA_RESET_WORD; // [RL21]
    // run and alarm summary
    machine_status_word[`CSA_ST_RUN]          = run_flag;         // [RL1]
    machine_status_word[`CSA_ST_STOP_ALARM]   = stop_alarm_flag;  // [RL1]
    machine_status_word[`CSA_ST_CONT_ALARM]   = cont_alarm_flag;  // [RL1]
    // maintenance, readiness and band conditions
    machine_status_word[`CSA_ST_MAINT_NOTICE] = maint_flag;       // [RL2]
    machine_status_word[`CSA_ST_READY_ONE]    = ready_one_flag;   // [RL3]
    machine_status_word[`CSA_ST_READY_TWO]    = ready_two_flag;   // [RL3]
    machine_status_word[`CSA_ST_TEMP_OUT]     = temp_out_flag;    // [RL4]
    // function settings
    machine_status_word[`CSA_ST_EXT_TUNE]     = ext_tune_flag;    // [RL5]
    machine_status_word[`CSA_ST_WARM_UP]      = warm_up_flag;     // [RL5]
    machine_status_word[`CSA_ST_STARTUP]      = startup_flag;     // [RL5]
    machine_status_word[`CSA_ST_ANTI_FREEZE]  = anti_freeze_flag; // [RL5]
  end

  // alarm word one: assigned bits follow their alarm, spares stay 0 [RL6] [RL21]
  reg  [15:0] alarm_word_one;
  always @* begin
    alarm_word_one = `CSA_RESET_WORD;
    // tank levels, channel one then channel two
    alarm_word_one[`CSA_AL1_LVL_ONE_ABN]  = al1_sync[`CSA_AL1_LVL_ONE_ABN];  // [RL7]
    alarm_word_one[`CSA_AL1_LVL_ONE_LOW]  = al1_sync[`CSA_AL1_LVL_ONE_LOW];  // [RL7]
    alarm_word_one[`CSA_AL1_LVL_TWO_ABN]  = al1_sync[`CSA_AL1_LVL_TWO_ABN];  // [RL7]
    alarm_word_one[`CSA_AL1_LVL_TWO_LOW]  = al1_sync[`CSA_AL1_LVL_TWO_LOW];  // [RL7]
    // fan
    alarm_word_one[`CSA_AL1_FAN_FAIL]     = al1_sync[`CSA_AL1_FAN_FAIL];     // [RL7]
    // channel one temperature alarms
    alarm_word_one[`CSA_AL1_ONE_RISE_ABN] = al1_sync[`CSA_AL1_ONE_RISE_ABN]; // [RL8]
    alarm_word_one[`CSA_AL1_ONE_RISE]     = al1_sync[`CSA_AL1_ONE_RISE];     // [RL8]
    alarm_word_one[`CSA_AL1_ONE_DROP]     = al1_sync[`CSA_AL1_ONE_DROP];     // [RL8]
    alarm_word_one[`CSA_AL1_ONE_READY]    = al1_sync[`CSA_AL1_ONE_READY];    // [RL8]
    // channel two temperature alarms
    alarm_word_one[`CSA_AL1_TWO_RISE_ABN] = al1_sync[`CSA_AL1_TWO_RISE_ABN]; // [RL8]
    alarm_word_one[`CSA_AL1_TWO_RISE]     = al1_sync[`CSA_AL1_TWO_RISE];     // [RL8]
    alarm_word_one[`CSA_AL1_TWO_DROP]     = al1_sync[`CSA_AL1_TWO_DROP];     // [RL8]
    alarm_word_one[`CSA_AL1_TWO_READY]    = al1_sync[`CSA_AL1_TWO_READY];    // [RL8]
    // mask again so a mistyped position can never expose a spare bit
    alarm_word_one = alarm_word_one & `CSA_AL1_USED_MASK; // [RL21]
  end

  // alarm word two: assigned bits follow their alarm, spares stay 0 [RL6] [RL21]
  reg  [15:0] alarm_word_two;
  always @* begin
    alarm_word_two = `CSA_RESET_WORD;
    // channel one inlet and pressure faults
    alarm_word_two[`CSA_AL2_ONE_INLET_HOT] = al2_sync[`CSA_AL2_ONE_INLET_HOT]; // [RL9]
    alarm_word_two[`CSA_AL2_ONE_PSENS]     = al2_sync[`CSA_AL2_ONE_PSENS];     // [RL9]
    alarm_word_two[`CSA_AL2_ONE_PRES_RISE] = al2_sync[`CSA_AL2_ONE_PRES_RISE]; // [RL9]
    alarm_word_two[`CSA_AL2_ONE_PRES_DROP] = al2_sync[`CSA_AL2_ONE_PRES_DROP]; // [RL9]
    // channel two inlet, pressure, flow and conductivity faults
    alarm_word_two[`CSA_AL2_TWO_INLET_HOT] = al2_sync[`CSA_AL2_TWO_INLET_HOT]; // [RL10]
    alarm_word_two[`CSA_AL2_TWO_PSENS]     = al2_sync[`CSA_AL2_TWO_PSENS];     // [RL10]
    alarm_word_two[`CSA_AL2_TWO_PRES_RISE] = al2_sync[`CSA_AL2_TWO_PRES_RISE]; // [RL10]
    alarm_word_two[`CSA_AL2_TWO_PRES_DROP] = al2_sync[`CSA_AL2_TWO_PRES_DROP]; // [RL10]
    alarm_word_two[`CSA_AL2_TWO_PRES_ABN]  = al2_sync[`CSA_AL2_TWO_PRES_ABN];  // [RL10]
    alarm_word_two[`CSA_AL2_TWO_FLOW_FAIL] = al2_sync[`CSA_AL2_TWO_FLOW_FAIL]; // [RL10]
    alarm_word_two[`CSA_AL2_TWO_COND_UP]   = al2_sync[`CSA_AL2_TWO_COND_UP];   // [RL10]
    // contact inputs
    alarm_word_two[`CSA_AL2_CONTACT_ONE]   = al2_sync[`CSA_AL2_CONTACT_ONE];   // [RL11]
    alarm_word_two[`CSA_AL2_CONTACT_TWO]   = al2_sync[`CSA_AL2_CONTACT_TWO];   // [RL11]
    alarm_word_two = alarm_word_two & `CSA_AL2_USED_MASK; // [RL21]
  end

  // alarm word three: assigned bits follow their alarm, spares stay 0 [RL6] [RL21]
  reg  [15:0] alarm_word_three;
  always @* begin
    alarm_word_three = `CSA_RESET_WORD;
    // system faults
    alarm_word_three[`CSA_AL3_COMM_ERR]      = al3_sync[`CSA_AL3_COMM_ERR];      // [RL12]
    alarm_word_three[`CSA_AL3_AMBIENT_OUT]   = al3_sync[`CSA_AL3_AMBIENT_OUT];   // [RL12]
    alarm_word_three[`CSA_AL3_MAINT_ALARM]   = al3_sync[`CSA_AL3_MAINT_ALARM];   // [RL12]
    alarm_word_three[`CSA_AL3_COMP_CIRCUIT]  = al3_sync[`CSA_AL3_COMP_CIRCUIT];  // [RL12]
    alarm_word_three[`CSA_AL3_SENSOR_FAIL]   = al3_sync[`CSA_AL3_SENSOR_FAIL];   // [RL12]
    // controller and inverters
    alarm_word_three[`CSA_AL3_CTRL_FAIL]     = al3_sync[`CSA_AL3_CTRL_FAIL];     // [RL13]
    alarm_word_three[`CSA_AL3_COMP_INV_ERR]  = al3_sync[`CSA_AL3_COMP_INV_ERR];  // [RL13]
    alarm_word_three[`CSA_AL3_COMP_INV_COMM] = al3_sync[`CSA_AL3_COMP_INV_COMM]; // [RL13]
    alarm_word_three[`CSA_AL3_PUMP_ONE_ERR]  = al3_sync[`CSA_AL3_PUMP_ONE_ERR];  // [RL13]
    alarm_word_three[`CSA_AL3_PUMP_ONE_COMM] = al3_sync[`CSA_AL3_PUMP_ONE_COMM]; // [RL13]
    alarm_word_three[`CSA_AL3_PUMP_TWO_ERR]  = al3_sync[`CSA_AL3_PUMP_TWO_ERR];  // [RL13]
    alarm_word_three[`CSA_AL3_PUMP_TWO_COMM] = al3_sync[`CSA_AL3_PUMP_TWO_COMM]; // [RL13]
    alarm_word_three = alarm_word_three & `CSA_AL3_USED_MASK; // [RL21]
  end

  // display words, one selector nibble each, lowest nibble first [RL19]
  wire [15:0] display_word_one;
  wire [15:0] display_word_two;
  wire [15:0] display_word_three;
  wire [15:0] display_word_four;

  // display word one: selector bits 3..0
  csa_display_sel u_disp_one (
    .sel_i           (data_select_i[3:0]), // [RL19]
    .ext_tune_on_i   (ext_tune_flag),      // [RL18]
    .ambient_temp_i  (ambient_temp_i),
    .ext_tune_temp_i (ext_tune_temp_i),
    .hx_inlet_temp_i (hx_inlet_temp_i),
    .maint_notice_i  (maint_notice_i),
    .hp_pressure_i   (hp_pressure_i),
    .word_o          (display_word_one)
  );

  // display word two: selector bits 7..4
  csa_display_sel u_disp_two (
    .sel_i           (data_select_i[7:4]), // [RL19]
    .ext_tune_on_i   (ext_tune_flag),      // [RL18]
    .ambient_temp_i  (ambient_temp_i),
    .ext_tune_temp_i (ext_tune_temp_i),
    .hx_inlet_temp_i (hx_inlet_temp_i),
    .maint_notice_i  (maint_notice_i),
    .hp_pressure_i   (hp_pressure_i),
    .word_o          (display_word_two)
  );

  // display word three: selector bits 11..8
  csa_display_sel u_disp_three (
    .sel_i           (data_select_i[11:8]), // [RL19]
    .ext_tune_on_i   (ext_tune_flag),       // [RL18]
    .ambient_temp_i  (ambient_temp_i),
    .ext_tune_temp_i (ext_tune_temp_i),
    .hx_inlet_temp_i (hx_inlet_temp_i),
    .maint_notice_i  (maint_notice_i),
    .hp_pressure_i   (hp_pressure_i),
    .word_o          (display_word_three)
  );

  // display word four: selector bits 15..12
  csa_display_sel u_disp_four (
    .sel_i           (data_select_i[15:12]), // [RL19]
    .ext_tune_on_i   (ext_tune_flag),        // [RL18]
    .ambient_temp_i  (ambient_temp_i),
    .ext_tune_temp_i (ext_tune_temp_i),
    .hx_inlet_temp_i (hx_inlet_temp_i),
    .maint_notice_i  (maint_notice_i),
    .hp_pressure_i   (hp_pressure_i),
    .word_o          (display_word_four)
  );

  // address decode; every word is read-only, writes are not accepted here
  reg  [15:0] next_rd_word;
  reg         next_rd_err;
  always @* begin
    next_rd_word = `CSA_RESET_WORD;
    next_rd_err  = 1'b0;
    case (rd_addr_i) // [RL20]
      `CSA_ADDR_DISPLAY_ONE:  next_rd_word = display_word_one;
      `CSA_ADDR_DISPLAY_TWO:  next_rd_word = display_word_two;
      `CSA_ADDR_DISPLAY_THR:  next_rd_word = display_word_three;
      `CSA_ADDR_DISPLAY_FOUR: next_rd_word = display_word_four;
      `CSA_ADDR_STATUS:       next_rd_word = machine_status_word;
      `CSA_ADDR_ALARM_ONE:    next_rd_word = alarm_word_one;
      `CSA_ADDR_ALARM_TWO:    next_rd_word = alarm_word_two;
      `CSA_ADDR_ALARM_THREE:  next_rd_word = alarm_word_three;
      // the front end turns this into its out-of-range answer
      default:                next_rd_err  = 1'b1;
    endcase
  end

  // data recirculates between reads, so the register loads on every edge
  wire [15:0] next_rd_data;
  assign next_rd_data = rd_en_i ? next_rd_word : rd_data_o; // [RL22]

  // answer pulses: one cycle, only for an accepted read
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_valid_o    <= 1'b0;
      rd_addr_err_o <= 1'b0;
    end else begin
      rd_valid_o    <= rd_en_i;
      rd_addr_err_o <= rd_en_i & next_rd_err;
    end
  end

  // read data stands until the next accepted read
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= `CSA_RESET_WORD;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule // csa_status_alarm_regs

/* File: tb/csa_regs_props.sv */
// concurrent checks on the read port and display words of the status and alarm bank
`timescale 1ns/1ps
module csa_regs_props (
  // watched ports
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        rd_en_i,
  input wire [15:0] rd_addr_i,
  input wire [15:0] rd_data_o,
  input wire        rd_valid_o,
  input wire        rd_addr_err_o,
  input wire [15:0] data_select_i,
  input wire [15:0] ambient_temp_i,
  input wire [15:0] maint_notice_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // 0038h..003Fh share the upper thirteen address bits
  wire in_map = rd_addr_i[15:3] == 13'h0007;
  read_answer_a: assert property (rd_en_i |=> rd_valid_o) else $error("read not answered");
  no_spurious_a: assert property (!rd_en_i |=> !rd_valid_o && $stable(rd_data_o)) else $error("output moved");
  unmapped_err_a: assert property (rd_en_i && !in_map |=> rd_addr_err_o && rd_data_o == 16'h0000)
    else $error("unmapped read");
  mapped_ok_a: assert property (rd_en_i && in_map |=> !rd_addr_err_o) else $error("mapped read refused");
  sel_none_a: assert property (rd_en_i && rd_addr_i == 16'h0038 && data_select_i[3:0] == 4'h0
    |=> rd_data_o == 16'h0000) else $error("code none not zero");
  clamp_high_a: assert property (rd_en_i && rd_addr_i == 16'h0039 && data_select_i[7:4] == 4'h1
    && $signed(ambient_temp_i) > 16'sh0CCC |=> rd_data_o == 16'h0CCC) else $error("no clamp");
  maint_raw_a: assert property (rd_en_i && rd_addr_i == 16'h0038 && data_select_i[3:0] == 4'h4
    |=> rd_data_o == $past(maint_notice_i)) else $error("maintenance set wrong");
  status_rsvd_a: assert property (rd_en_i && rd_addr_i == 16'h003C |=> rd_data_o[11:7] == 5'h00)
    else $error("status spare set");
  alarm_rsvd_a: assert property (rd_en_i && rd_addr_i == 16'h003D |=> (rd_data_o & 16'h00D0) == 16'h0000)
    else $error("alarm spare set");
endmodule // csa_regs_props

bind csa_status_alarm_regs csa_regs_props csa_regs_props_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .rd_addr_err_o(rd_addr_err_o), .data_select_i(data_select_i), .ambient_temp_i(ambient_temp_i),
  .maint_notice_i(maint_notice_i));

/* File: tb/csa_host_model.sv */
// polling host: issues single word reads on the bank's read port
`timescale 1ns/1ps
module csa_host_model (
  // read port
  input  wire        clk_i,
  input  wire [15:0] rd_data_i,
  input  wire        rd_valid_i,
  input  wire        rd_addr_err_i,
  output reg         rd_en_o,
  output reg  [15:0] rd_addr_o
);
  initial begin
    rd_en_o = 1'b0;
    rd_addr_o = 16'h0000;
  end
  // request held across one taking edge; answer sampled on the falling edge half a cycle after it
  task rd(input [15:0] a, output [15:0] d, output [1:0] f);
    begin
      @(negedge clk_i);
      rd_en_o = 1'b1;
      rd_addr_o = a;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      rd_addr_o = ~a;
      d = rd_data_i;
      f = {rd_valid_i, rd_addr_err_i};
    end
  endtask
endmodule // csa_host_model

/* File: tb/tb_csa_status_alarm_regs.sv */
// self-checking bench for the status, alarm and display bank
`timescale 1ns/1ps
module tb_csa_status_alarm_regs;
  reg         sys_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [15:0] sel = 16'h0000, amb = 16'h1000, ext = 16'h0123, hx = 16'h8000, mnt = 16'hA5C3, hp = 16'h7FFF;
  reg  [10:0] flg = 11'h000;
  reg  [15:0] al [0:2];
  reg  [15:0] mask [0:2];
  wire        en, vld, err;
  wire [15:0] addr, dat;
  integer     num_errors = 0, checks = 0, cyc = 0, i, k;
  initial forever #25 sys_clk = ~sys_clk;
  csa_status_alarm_regs csa_status_alarm_regs_inst (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .rd_en_i(en),
    .rd_addr_i(addr), .rd_data_o(dat), .rd_valid_o(vld), .rd_addr_err_o(err), .data_select_i(sel),
    .running_i(flg[0]), .stop_alarm_i(flg[1]), .cont_alarm_i(flg[2]), .maint_notice_flag_i(flg[3]),
    .ready_channel_one_i(flg[4]), .ready_channel_two_i(flg[5]), .temp_out_i(flg[6]), .ext_tune_on_i(flg[7]),
    .warm_up_on_i(flg[8]), .startup_on_i(flg[9]), .anti_freeze_on_i(flg[10]), .alarm_one_i(al[0]),
    .alarm_two_i(al[1]), .alarm_three_i(al[2]), .ambient_temp_i(amb), .ext_tune_temp_i(ext),
    .hx_inlet_temp_i(hx), .maint_notice_i(mnt), .hp_pressure_i(hp));
  csa_host_model csa_host_model_inst (.clk_i(sys_clk), .rd_data_i(dat), .rd_valid_i(vld),
    .rd_addr_err_i(err), .rd_en_o(en), .rd_addr_o(addr));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [15:0] a, input [15:0] exp, input [1:0] ef);
    reg [15:0] d;
    reg [1:0]  f;
    begin
      csa_host_model_inst.rd(a, d, f);
      chk(d, exp);
      chk({14'h0000, f}, {14'h0000, ef});
    end
  endtask
  // flags pass two synchroniser stages, so allow settling before reading
  task settle;
    repeat (4) @(negedge sys_clk);
  endtask
  task stop_test;
    begin
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  initial begin
    mask[0] = 16'hFF2F;
    mask[1] = 16'h67FF;
    mask[2] = 16'h1FFE;
    for (i = 0; i < 3; i = i + 1)
      al[i] = 16'h0000;
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    rdchk(16'h003C, 16'h0000, 2'b10);
    for (k = 0; k < 11; k = k + 1) begin
      flg = 11'h001 << k;
      settle;
      rdchk(16'h003C, 16'h0001 << (k < 7 ? k : k + 5), 2'b10);
    end
    flg = 11'h7FF;
    settle;
    rdchk(16'h003C, 16'hF07F, 2'b10);
    for (k = 0; k < 3; k = k + 1) begin
      al[k] = 16'hFFFF;
      settle;
      rdchk(16'(16'h003D + k), mask[k], 2'b10);
      al[k] = 16'h5A5A;
      settle;
      rdchk(16'(16'h003D + k), 16'h5A5A & mask[k], 2'b10);
      al[k] = 16'h0000;
      settle;
      rdchk(16'(16'h003D + k), 16'h0000, 2'b10);
    end
    for (k = 0; k < 7; k = k + 1) begin
      sel = 16'(k << (4 * (k % 4)));
      rdchk(16'(16'h0038 + k % 4), k == 1 ? 16'h0CCC : k == 2 ? 16'h0123 : k == 3 ? 16'hF334 :
        k == 4 ? 16'hA5C3 : k == 5 ? 16'h0CCC : 16'h0000, 2'b10);
    end
    flg = 11'h000;
    settle;
    sel = 16'h2000;
    rdchk(16'h003B, 16'hF334, 2'b10);
    rdchk(16'h0037, 16'h0000, 2'b11);
    rdchk(16'h0040, 16'h0000, 2'b11);
    stop_test;
  end
endmodule // tb_csa_status_alarm_regs
